// File: verification/board_reset_led_ctrl_regs_properties.sv
`timescale 1ns/1ps
module board_reset_led_ctrl_regs_properties
	import board_ctrl_pkg::*;
(
	input wire logic       sys_clk_in, rst_in, reg_wr_in, reg_rd_in,
	input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
	input wire logic [4:0] mgmt_reset_req_in, mgmt_reset_gated_out,
	input wire logic       host_pcie_reset_in, asic_pcie_reset_out,
	input wire logic       mgmt_asic_power_req_in, mgmt_asic_power_out,
	input wire logic       mgmt_host_power_req_in, mgmt_host_power_out,
	input wire logic       fan_card_reset_n_out, usb_i2c_bridge_reset_n_out, usb_hub_reset_n_out,
	input wire logic       mgmt_switch_reset_n_out, front_phy_reset_n_out, onboard_phy_reset_n_out,
	input wire logic       usb_spi_bridge_reset_n_out, pll_reset_n_out,
	input wire logic       led_button_state_out, lower_port_first_out,
	input wire logic [15:0] stream_zero_swap_mask_out
);
	logic [7:0] resets_n;
	assign resets_n = {pll_reset_n_out, usb_spi_bridge_reset_n_out, onboard_phy_reset_n_out,
		front_phy_reset_n_out, mgmt_switch_reset_n_out, usb_hub_reset_n_out,
		usb_i2c_bridge_reset_n_out, fan_card_reset_n_out};
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	a_read_resets: assert property (reg_rd_in && reg_addr_in == PERIPH_RESET_OFFSET
		|=> reg_rdata_out == resets_n) else $error("reset register readback differs from pins");
	a_idle_rdata_zero: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
		else $error("read data not zero outside read answer");
	a_write_resets: assert property (reg_wr_in && reg_addr_in == PERIPH_RESET_OFFSET
		|=> resets_n == $past(reg_wdata_in)) else $error("reset pins do not follow write");
	a_resets_hold: assert property (!(reg_wr_in && reg_addr_in == PERIPH_RESET_OFFSET)
		|=> $stable(resets_n)) else $error("reset pins changed without write");
	a_mgmt_gate_and: assert property (reg_rd_in && reg_addr_in == MGMT_ENABLE_OFFSET
		|=> mgmt_reset_gated_out == (mgmt_reset_req_in & reg_rdata_out[4:0]))
		else $error("management request gating wrong");
	a_pcie_propagate: assert property (reg_rd_in && reg_addr_in == GENERAL_ENABLE_OFFSET
		|=> asic_pcie_reset_out == (host_pcie_reset_in & reg_rdata_out[3]))
		else $error("pcie reset propagation wrong");
	a_power_permit: assert property (reg_rd_in && reg_addr_in == GENERAL_ENABLE_OFFSET
		|=> mgmt_asic_power_out == (mgmt_asic_power_req_in & reg_rdata_out[4])
		&& mgmt_host_power_out == (mgmt_host_power_req_in & reg_rdata_out[5]))
		else $error("power permit gating wrong");
	a_toggle_flip: assert property (reg_wr_in && reg_addr_in == BUTTON_TOGGLE_OFFSET
		&& reg_wdata_in[0] |=> led_button_state_out != $past(led_button_state_out))
		else $error("button state did not toggle");
	a_order_write: assert property (reg_wr_in && reg_addr_in == STREAM_ORDER_OFFSET
		|=> lower_port_first_out == $past(reg_wdata_in[0])) else $error("order bit not taken");
	a_swap_low: assert property (reg_wr_in && reg_addr_in == ZERO_SWAP_LOW_OFFSET
		|=> stream_zero_swap_mask_out[7:0] == $past(reg_wdata_in)) else $error("swap low byte lost");
endmodule : board_reset_led_ctrl_regs_properties

bind board_reset_led_ctrl_regs board_reset_led_ctrl_regs_properties i_props (.*);

// File: verification/board_reset_led_ctrl_regs_tb.sv
`timescale 1ns/1ps
module board_reset_led_ctrl_regs_tb;
	import board_ctrl_pkg::*;
	logic        sys_clk_in, rst_in, reg_wr_in, reg_rd_in, pcie, apwr, hpwr, s1_bl, s2_bl;
	logic        btn_st, lower, rd_pending, exp_btn;
	logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, rd_exp;
	wire  [7:0]  resets_n;
	logic [12:0] req;
	logic [4:0]  mgmt_g, num;
	logic [1:0]  wdog_g;
	logic [2:0]  btn_g, rgb, s1_rgb, s2_rgb;
	wire  [2:0]  tsel;
	wire  [5:0]  ledc;
	logic [23:0] pat;
	logic [15:0] sw0, sw1;
	logic [31:0] seed, v;
	logic [7:0]  m [8'h39:8'h49];
	int          n_fail, total_checks;

	board_reset_led_ctrl_regs i_board_reset_led_ctrl_regs (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .mgmt_reset_req_in(req[4:0]),
		.mgmt_watchdog_req_in(req[6:5]), .button_reset_req_in(req[9:7]),
		.host_pcie_reset_in(req[10]), .mgmt_asic_power_req_in(req[11]),
		.mgmt_host_power_req_in(req[12]), .fan_card_reset_n_out(resets_n[0]),
		.usb_i2c_bridge_reset_n_out(resets_n[1]), .usb_hub_reset_n_out(resets_n[2]),
		.mgmt_switch_reset_n_out(resets_n[3]), .front_phy_reset_n_out(resets_n[4]),
		.onboard_phy_reset_n_out(resets_n[5]), .usb_spi_bridge_reset_n_out(resets_n[6]),
		.pll_reset_n_out(resets_n[7]), .mgmt_reset_gated_out(mgmt_g),
		.mgmt_watchdog_gated_out(wdog_g), .button_reset_gated_out(btn_g),
		.asic_pcie_reset_out(pcie), .mgmt_asic_power_out(apwr), .mgmt_host_power_out(hpwr),
		.asic_led_stream_clear_out(ledc[0]), .asic_led_stream_on_out(ledc[1]),
		.alt_stream_format_on_out(ledc[2]), .walk_test_on_out(ledc[3]),
		.port_test_blink_out(ledc[4]), .port_test_mode_out(ledc[5]),
		.stream_zero_test_out(tsel[2]), .stream_one_test_out(tsel[1]),
		.single_led_test_out(tsel[0]), .test_led_num_out(num), .test_rgb_out(rgb),
		.sys_led_one_rgb_out(s1_rgb), .sys_led_one_blink_out(s1_bl),
		.sys_led_two_rgb_out(s2_rgb), .sys_led_two_blink_out(s2_bl),
		.led_test_pattern_out(pat), .stream_zero_swap_mask_out(sw0),
		.stream_one_swap_mask_out(sw1), .led_button_state_out(btn_st),
		.lower_port_first_out(lower)
	);

	// ----------------------------------------
	// expectations
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [7:0] rst_val(input logic [7:0] a);
		case (a)
			8'h39: return 8'hFF;
			8'h3A: return 8'h80;
			8'h3B: return 8'h8F;
			8'h3C, 8'h3D: return 8'hE0;
			8'h3E, 8'h3F: return 8'hFE;
			default: return 8'h00;
		endcase
	endfunction : rst_val

	function automatic logic [7:0] rexp(input logic [7:0] a);
		return (a >= 8'h39 && a <= 8'h49) ? m[a] : 8'h00;
	endfunction : rexp

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic summarize();
		if (n_fail == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize

	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		v = rnd();
		reg_wr_in <= w;
		reg_rd_in <= r;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		req <= v[12:0];
		@(posedge sys_clk_in);
		rd_pending = r;
		rd_exp = rexp(a);
		if (w && a >= 8'h39 && a <= 8'h47) begin
			m[a] = d;
		end
		if (w && a == 8'h49) begin
			m[a] = {7'h00, d[0]};
		end
		if (w && a == 8'h48) begin
			exp_btn ^= d[0];
		end
	endtask : op

	task automatic do_reset();
		rst_in <= 1'b1;
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
		repeat (8) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		for (int i = 8'h39; i <= 8'h49; i++) begin
			m[i] = rst_val(i[7:0]);
		end
		exp_btn = 1'b0;
		rd_pending = 1'b0;
	endtask : do_reset

	// outputs are compared mid-cycle, once every edge update has landed
	always @(negedge sys_clk_in) begin
		if (!rst_in) begin
			chk(reg_rdata_out, rd_pending ? rd_exp : 8'h00);
			chk(resets_n, m[8'h39]);
			chk(mgmt_g, req[4:0] & m[8'h3A][4:0]);
			chk(wdog_g, req[6:5] & m[8'h3A][6:5]);
			chk(btn_g, req[9:7] & m[8'h3B][2:0]);
			chk({hpwr, apwr, pcie}, req[12:10] & m[8'h3B][5:3]);
			chk(ledc, {m[8'h3C][7:6], m[8'h3C][3:0]});
			chk(tsel, {~m[8'h3C][4], m[8'h3C][4], ~m[8'h3C][5]});
			chk({rgb, num}, {m[8'h3D][7], m[8'h3D][5], m[8'h3D][6], m[8'h3D][4:0]});
			chk({s1_bl, s1_rgb}, {m[8'h3E][3], m[8'h3E][0], m[8'h3E][1], m[8'h3E][2]});
			chk({s2_bl, s2_rgb}, {m[8'h3F][3], m[8'h3F][0], m[8'h3F][1], m[8'h3F][2]});
			chk(pat, {m[8'h43][5:0], m[8'h42][5:0], m[8'h41][5:0], m[8'h40][5:0]});
			chk({sw1, sw0}, {m[8'h47], m[8'h46], m[8'h45], m[8'h44]});
			chk({btn_st, lower}, {exp_btn, m[8'h49][0]});
		end
	end

	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	initial begin
		repeat (100000) @(posedge sys_clk_in);
		n_fail++;
		summarize();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h00000033;
		n_fail = 0;
		total_checks = 0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 8'h00;
		req = 13'h0000;
		do_reset();
		for (int i = 8'h38; i <= 8'h4A; i++) op(1'b0, 1'b1, i[7:0], 8'h00);
		op(1'b1, 1'b0, 8'h39, 8'h00);
		op(1'b0, 1'b1, 8'h39, 8'h00);
		op(1'b1, 1'b0, 8'h48, 8'h01);
		op(1'b1, 1'b0, 8'h48, 8'h01);
		op(1'b1, 1'b0, 8'h48, 8'hFE);
		op(1'b0, 1'b1, 8'h48, 8'h00);
		op(1'b1, 1'b0, 8'h49, 8'hFF);
		op(1'b0, 1'b1, 8'h49, 8'h00);
		op(1'b1, 1'b0, 8'h3A, 8'hFF);
		op(1'b0, 1'b1, 8'h3A, 8'h00);
		op(1'b1, 1'b0, 8'h3B, 8'h7F);
		op(1'b0, 1'b1, 8'h3B, 8'h00);
		op(1'b1, 1'b0, 8'h50, 8'h77);
		op(1'b0, 1'b1, 8'h50, 8'h00);
		for (int i = 0; i < 4; i++) op(1'b1, 1'b0, 8'h3C, {2'b11, i[1:0], 4'hF});
		for (int i = 0; i < 400; i++) begin
			v = rnd();
			op(v[8], v[9] & ~v[8], 8'h38 + {3'b000, v[4:0]}, v[23:16]);
		end
		do_reset();
		for (int i = 8'h39; i <= 8'h49; i++) op(1'b0, 1'b1, i[7:0], 8'h00);
		op(1'b0, 1'b0, 8'h00, 8'h00);
		@(posedge sys_clk_in);
		summarize();
	end
endmodule : board_reset_led_ctrl_regs_tb

// File: verilog/board_ctrl_pkg.sv
package board_ctrl_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] PERIPH_RESET_OFFSET  = 8'h39;
	localparam logic [7:0] MGMT_ENABLE_OFFSET   = 8'h3A;
	localparam logic [7:0] GENERAL_ENABLE_OFFSET = 8'h3B;
	localparam logic [7:0] ASIC_LED_OFFSET      = 8'h3C;
	localparam logic [7:0] TEST_LED_OFFSET      = 8'h3D;
	localparam logic [7:0] SYS_LED_ONE_OFFSET   = 8'h3E;
	localparam logic [7:0] SYS_LED_TWO_OFFSET   = 8'h3F;
	localparam logic [7:0] TOP_TEST_LOW_OFFSET  = 8'h40;
	localparam logic [7:0] TOP_TEST_HIGH_OFFSET = 8'h41;
	localparam logic [7:0] BOT_TEST_LOW_OFFSET  = 8'h42;
	localparam logic [7:0] BOT_TEST_HIGH_OFFSET = 8'h43;
	localparam logic [7:0] ZERO_SWAP_LOW_OFFSET = 8'h44;
	localparam logic [7:0] ZERO_SWAP_HIGH_OFFSET = 8'h45;
	localparam logic [7:0] ONE_SWAP_LOW_OFFSET  = 8'h46;
	localparam logic [7:0] ONE_SWAP_HIGH_OFFSET = 8'h47;
	localparam logic [7:0] BUTTON_TOGGLE_OFFSET = 8'h48;
	localparam logic [7:0] STREAM_ORDER_OFFSET  = 8'h49;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] PERIPH_RESET_INIT   = 8'hFF;
	localparam logic [7:0] MGMT_ENABLE_INIT    = 8'h80;
	localparam logic [7:0] GENERAL_ENABLE_INIT = 8'h8F;
	localparam logic [7:0] ASIC_LED_INIT       = 8'hE0;
	localparam logic [7:0] TEST_LED_INIT       = 8'hE0;
	localparam logic [7:0] SYS_LED_INIT        = 8'hFE;
	localparam logic [7:0] ZERO_INIT           = 8'h00;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int PERIPH_OUT_BITS     = 8;
	localparam int MGMT_REQ_BITS       = 5;
	localparam int MGMT_WDOG_LSB       = 5;
	localparam int MGMT_WDOG_BITS      = 2;
	localparam int BUTTON_BITS         = 3;
	localparam int PCIE_PROP_BIT       = 3;
	localparam int ASIC_PWR_BIT        = 4;
	localparam int HOST_PWR_BIT        = 5;
	localparam int LED_CLEAR_BIT       = 0;
	localparam int LED_ON_BIT          = 1;
	localparam int ALT_FORMAT_BIT      = 2;
	localparam int WALK_TEST_BIT       = 3;
	localparam int TEST_SEL_LSB        = 4;
	localparam int TEST_BLINK_BIT      = 6;
	localparam int TEST_MODE_BIT       = 7;
	localparam int TEST_NUM_BITS       = 5;
	localparam int TEST_GREEN_BIT      = 5;
	localparam int TEST_BLUE_BIT       = 6;
	localparam int TEST_RED_BIT        = 7;
	localparam int SYS_RED_BIT         = 0;
	localparam int SYS_GREEN_BIT       = 1;
	localparam int SYS_BLUE_BIT        = 2;
	localparam int SYS_BLINK_BIT       = 3;
	localparam int TOGGLE_BIT          = 0;
	localparam int ORDER_BIT           = 0;
	localparam int SWAP_BITS           = 16;

	// ----------------------------------------
	// led test selection
	// ----------------------------------------
	typedef enum logic [1:0] {
		SINGLE_STREAM_ZERO = 2'b00,
		SINGLE_STREAM_ONE  = 2'b01,
		ALL_STREAM_ZERO    = 2'b10,
		ALL_STREAM_ONE     = 2'b11
	} led_test_sel_type;

endpackage : board_ctrl_pkg

// File: verilog/board_reset_led_ctrl_regs.sv
// How it works
// RQ1: bits 0-5 of peripheral reset register drive six active-low device resets, reset high.
// RQ2: bits 6-7 drive reserved spi-bridge and pll active-low resets, reset high.
// RQ3: management reset gates bits 0-4 pass main and requests one-four; reset blocked.
// RQ4: bits 5-6 gate management watchdog requests, reset zero; bit 7 reserved, reset one.
// RQ5: general enable bits 0-2 gate front, board and vendor button requests; reset on.
// RQ6: bit 3 set lets host pcie reset propagate to asic pcie reset.
// RQ7: bits 4 and 5 permit management power control of asic and host; reset off.
// RQ8: led control bit 0 clears both streams, bit 1 enables them; reset zero.
// RQ9: bit 2 selects the alternate vendor stream format; reset normal.
// RQ10: bit 3 runs the led walk test; reset disabled.
// RQ11: bits 5:4 select single or all led test on stream zero or one.
// RQ12: bit 7 enables port led test mode, bit 6 makes it blink; reset one.
// RQ13: five-bit test number picks one of 32 leds in a stream; reset zero.
// RQ14: test green, blue and red lit only when bits 5, 6, 7 set.
// RQ15: system led one red, green, blue from bits 0-2, blink bit 3.
// RQ16: system led two red, green, blue from bits 0-2, blink bit 3.
// RQ17: two 16-bit swap masks, low and high bytes at consecutive offsets; reset zero.
// RQ18: writing one to toggle bit 0 flips the led selection state; write-only.
// RQ19: order bit 0 low sends upper port first, high sends lower port first.
// RQ20: software should set the order bit so the lower port goes first.
// RQ21: each active-low reset output follows its register bit until rewritten.
// RQ22: each enable bit is ANDed with its request before reset generation.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module board_reset_led_ctrl_regs
	import board_ctrl_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic [7:0]       reg_rdata_out,
	input  wire logic [4:0]  mgmt_reset_req_in,
	input  wire logic [1:0]  mgmt_watchdog_req_in,
	input  wire logic [2:0]  button_reset_req_in,
	input  wire logic        host_pcie_reset_in,
	input  wire logic        mgmt_asic_power_req_in,
	input  wire logic        mgmt_host_power_req_in,
	output logic             fan_card_reset_n_out,
	output logic             usb_i2c_bridge_reset_n_out,
	output logic             usb_hub_reset_n_out,
	output logic             mgmt_switch_reset_n_out,
	output logic             front_phy_reset_n_out,
	output logic             onboard_phy_reset_n_out,
	output logic             usb_spi_bridge_reset_n_out,
	output logic             pll_reset_n_out,
	output logic [4:0]       mgmt_reset_gated_out,
	output logic [1:0]       mgmt_watchdog_gated_out,
	output logic [2:0]       button_reset_gated_out,
	output logic             asic_pcie_reset_out,
	output logic             mgmt_asic_power_out,
	output logic             mgmt_host_power_out,
	output logic             asic_led_stream_clear_out,
	output logic             asic_led_stream_on_out,
	output logic             alt_stream_format_on_out,
	output logic             walk_test_on_out,
	output logic             port_test_mode_out,
	output logic             port_test_blink_out,
	output logic             stream_zero_test_out,
	output logic             stream_one_test_out,
	output logic             single_led_test_out,
	output logic [4:0]       test_led_num_out,
	output logic [2:0]       test_rgb_out,
	output logic [2:0]       sys_led_one_rgb_out,
	output logic             sys_led_one_blink_out,
	output logic [2:0]       sys_led_two_rgb_out,
	output logic             sys_led_two_blink_out,
	output logic [23:0]      led_test_pattern_out,
	output logic [15:0]      stream_zero_swap_mask_out,
	output logic [15:0]      stream_one_swap_mask_out,
	output logic             led_button_state_out,
	output logic             lower_port_first_out
);

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [7:0] peripheral_reset_ctrl_reg;
	logic [7:0] mgmt_reset_enable_reg;
	logic [7:0] general_reset_enable_reg;
	logic [7:0] asic_led_ctrl_reg;
	logic [7:0] test_led_select_reg;
	logic [7:0] system_led_one_reg;
	logic [7:0] system_led_two_reg;
	logic [7:0] top_led_test_low_reg;
	logic [7:0] top_led_test_high_reg;
	logic [7:0] bottom_led_test_low_reg;
	logic [7:0] bottom_led_test_high_reg;
	logic [7:0] stream_zero_swap_low_reg;
	logic [7:0] stream_zero_swap_high_reg;
	logic [7:0] stream_one_swap_low_reg;
	logic [7:0] stream_one_swap_high_reg;
	logic       led_button_state_reg;
	logic       led_stream_order_reg;
	logic [7:0] read_next;

	reg_port_if bus ();

	assign bus.addr  = reg_addr_in;
	assign bus.wdata = reg_wdata_in;
	assign bus.wr    = reg_wr_in;
	assign bus.rd    = reg_rd_in;

	function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] off);
		wr_hit = wr && (a == off);
	endfunction : wr_hit

	// ----------------------------------------
	// reset and enable registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			peripheral_reset_ctrl_reg <= PERIPH_RESET_INIT; // RQ1
			mgmt_reset_enable_reg     <= MGMT_ENABLE_INIT; // RQ3
			general_reset_enable_reg  <= GENERAL_ENABLE_INIT; // RQ5
		end else begin
			if (wr_hit(bus.wr, bus.addr, PERIPH_RESET_OFFSET)) begin
				peripheral_reset_ctrl_reg <= bus.wdata; // RQ21
			end
			if (wr_hit(bus.wr, bus.addr, MGMT_ENABLE_OFFSET)) begin
				mgmt_reset_enable_reg <= bus.wdata; // RQ4
			end
			if (wr_hit(bus.wr, bus.addr, GENERAL_ENABLE_OFFSET)) begin
				general_reset_enable_reg <= bus.wdata;
			end
		end
	end

	// ----------------------------------------
	// led control registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			asic_led_ctrl_reg   <= ASIC_LED_INIT; // RQ12
			test_led_select_reg <= TEST_LED_INIT; // RQ14
			system_led_one_reg  <= SYS_LED_INIT; // RQ15
			system_led_two_reg  <= SYS_LED_INIT; // RQ16
		end else begin
			if (wr_hit(bus.wr, bus.addr, ASIC_LED_OFFSET)) begin
				asic_led_ctrl_reg <= bus.wdata;
			end
			if (wr_hit(bus.wr, bus.addr, TEST_LED_OFFSET)) begin
				test_led_select_reg <= bus.wdata;
			end
			if (wr_hit(bus.wr, bus.addr, SYS_LED_ONE_OFFSET)) begin
				system_led_one_reg <= bus.wdata;
			end
			if (wr_hit(bus.wr, bus.addr, SYS_LED_TWO_OFFSET)) begin
				system_led_two_reg <= bus.wdata;
			end
		end
	end

	// ----------------------------------------
	// led test pattern and swap registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			top_led_test_low_reg      <= ZERO_INIT;
			top_led_test_high_reg     <= ZERO_INIT;
			bottom_led_test_low_reg   <= ZERO_INIT;
			bottom_led_test_high_reg  <= ZERO_INIT;
			stream_zero_swap_low_reg  <= ZERO_INIT; // RQ17
			stream_zero_swap_high_reg <= ZERO_INIT;
			stream_one_swap_low_reg   <= ZERO_INIT;
			stream_one_swap_high_reg  <= ZERO_INIT;
		end else begin
			if (wr_hit(bus.wr, bus.addr, TOP_TEST_LOW_OFFSET)) begin
				top_led_test_low_reg <= bus.wdata;
			end
			if (wr_hit(bus.wr, bus.addr, TOP_TEST_HIGH_OFFSET)) begin
				top_led_test_high_reg <= bus.wdata;
			end
			if (wr_hit(bus.wr, bus.addr, BOT_TEST_LOW_OFFSET)) begin
				bottom_led_test_low_reg <= bus.wdata;
			end
			if (wr_hit(bus.wr, bus.addr, BOT_TEST_HIGH_OFFSET)) begin
				bottom_led_test_high_reg <= bus.wdata;
			end
			if (wr_hit(bus.wr, bus.addr, ZERO_SWAP_LOW_OFFSET)) begin
				stream_zero_swap_low_reg <= bus.wdata; // RQ17
			end
			if (wr_hit(bus.wr, bus.addr, ZERO_SWAP_HIGH_OFFSET)) begin
				stream_zero_swap_high_reg <= bus.wdata; // RQ17
			end
			if (wr_hit(bus.wr, bus.addr, ONE_SWAP_LOW_OFFSET)) begin
				stream_one_swap_low_reg <= bus.wdata; // RQ17
			end
			if (wr_hit(bus.wr, bus.addr, ONE_SWAP_HIGH_OFFSET)) begin
				stream_one_swap_high_reg <= bus.wdata; // RQ17
			end
		end
	end

	// ----------------------------------------
	// button toggle and stream order
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			led_button_state_reg <= 1'b0;
			led_stream_order_reg <= 1'b0;
		end else begin
			if (wr_hit(bus.wr, bus.addr, BUTTON_TOGGLE_OFFSET) && bus.wdata[TOGGLE_BIT]) begin
				led_button_state_reg <= ~led_button_state_reg; // RQ18
			end
			if (wr_hit(bus.wr, bus.addr, STREAM_ORDER_OFFSET)) begin
				led_stream_order_reg <= bus.wdata[ORDER_BIT]; // RQ19
			end
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb begin
		unique case (bus.addr)
			PERIPH_RESET_OFFSET:   read_next = peripheral_reset_ctrl_reg;
			MGMT_ENABLE_OFFSET:    read_next = mgmt_reset_enable_reg;
			GENERAL_ENABLE_OFFSET: read_next = general_reset_enable_reg;
			ASIC_LED_OFFSET:       read_next = asic_led_ctrl_reg;
			TEST_LED_OFFSET:       read_next = test_led_select_reg;
			SYS_LED_ONE_OFFSET:    read_next = system_led_one_reg;
			SYS_LED_TWO_OFFSET:    read_next = system_led_two_reg;
			TOP_TEST_LOW_OFFSET:   read_next = top_led_test_low_reg;
			TOP_TEST_HIGH_OFFSET:  read_next = top_led_test_high_reg;
			BOT_TEST_LOW_OFFSET:   read_next = bottom_led_test_low_reg;
			BOT_TEST_HIGH_OFFSET:  read_next = bottom_led_test_high_reg;
			ZERO_SWAP_LOW_OFFSET:  read_next = stream_zero_swap_low_reg;
			ZERO_SWAP_HIGH_OFFSET: read_next = stream_zero_swap_high_reg;
			ONE_SWAP_LOW_OFFSET:   read_next = stream_one_swap_low_reg;
			ONE_SWAP_HIGH_OFFSET:  read_next = stream_one_swap_high_reg;
			// toggle bit is write-only and reads zero
			BUTTON_TOGGLE_OFFSET:  read_next = ZERO_INIT;
			STREAM_ORDER_OFFSET:   read_next = {7'h00, led_stream_order_reg};
			default:               read_next = ZERO_INIT;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			bus.rdata <= ZERO_INIT;
		end else if (bus.rd) begin
			bus.rdata <= read_next;
		end else begin
			bus.rdata <= ZERO_INIT;
		end
	end

	assign reg_rdata_out = bus.rdata;

	// ----------------------------------------
	// reset outputs and request gating
	// ----------------------------------------
	assign fan_card_reset_n_out       = peripheral_reset_ctrl_reg[0]; // RQ1
	assign usb_i2c_bridge_reset_n_out = peripheral_reset_ctrl_reg[1]; // RQ1
	assign usb_hub_reset_n_out        = peripheral_reset_ctrl_reg[2]; // RQ1
	assign mgmt_switch_reset_n_out    = peripheral_reset_ctrl_reg[3]; // RQ1
	assign front_phy_reset_n_out      = peripheral_reset_ctrl_reg[4]; // RQ1
	assign onboard_phy_reset_n_out    = peripheral_reset_ctrl_reg[5]; // RQ1
	assign usb_spi_bridge_reset_n_out = peripheral_reset_ctrl_reg[6]; // RQ2
	assign pll_reset_n_out            = peripheral_reset_ctrl_reg[7]; // RQ2

	assign mgmt_reset_gated_out = mgmt_reset_req_in
		& mgmt_reset_enable_reg[MGMT_REQ_BITS-1:0]; // RQ3
	assign mgmt_watchdog_gated_out = mgmt_watchdog_req_in
		& mgmt_reset_enable_reg[MGMT_WDOG_LSB +: MGMT_WDOG_BITS]; // RQ22
	assign button_reset_gated_out = button_reset_req_in
		& general_reset_enable_reg[BUTTON_BITS-1:0]; // RQ5
	assign asic_pcie_reset_out = host_pcie_reset_in
		& general_reset_enable_reg[PCIE_PROP_BIT]; // RQ6
	assign mgmt_asic_power_out = mgmt_asic_power_req_in
		& general_reset_enable_reg[ASIC_PWR_BIT]; // RQ7
	assign mgmt_host_power_out = mgmt_host_power_req_in
		& general_reset_enable_reg[HOST_PWR_BIT]; // RQ7

	// ----------------------------------------
	// led outputs
	// ----------------------------------------
	assign asic_led_stream_clear_out = asic_led_ctrl_reg[LED_CLEAR_BIT]; // RQ8
	assign asic_led_stream_on_out    = asic_led_ctrl_reg[LED_ON_BIT]; // RQ8
	assign alt_stream_format_on_out  = asic_led_ctrl_reg[ALT_FORMAT_BIT]; // RQ9
	assign walk_test_on_out          = asic_led_ctrl_reg[WALK_TEST_BIT]; // RQ10
	assign port_test_mode_out        = asic_led_ctrl_reg[TEST_MODE_BIT]; // RQ12
	assign port_test_blink_out       = asic_led_ctrl_reg[TEST_BLINK_BIT]; // RQ12

	test_led_decode i_test_led_decode (
		.asic_led_in          (asic_led_ctrl_reg),
		.test_led_in          (test_led_select_reg),
		.stream_zero_test_out (stream_zero_test_out),
		.stream_one_test_out  (stream_one_test_out),
		.single_led_out       (single_led_test_out),
		.test_led_num_out     (test_led_num_out),
		.test_rgb_out         (test_rgb_out)
	);

	assign sys_led_one_rgb_out = {system_led_one_reg[SYS_RED_BIT],
		system_led_one_reg[SYS_GREEN_BIT], system_led_one_reg[SYS_BLUE_BIT]}; // RQ15
	assign sys_led_one_blink_out = system_led_one_reg[SYS_BLINK_BIT]; // RQ15
	assign sys_led_two_rgb_out = {system_led_two_reg[SYS_RED_BIT],
		system_led_two_reg[SYS_GREEN_BIT], system_led_two_reg[SYS_BLUE_BIT]}; // RQ16
	assign sys_led_two_blink_out = system_led_two_reg[SYS_BLINK_BIT]; // RQ16

	// raw colour fields: lowest six bits of each pattern register, enables not exported
	assign led_test_pattern_out = {bottom_led_test_high_reg[5:0], bottom_led_test_low_reg[5:0],
		top_led_test_high_reg[5:0], top_led_test_low_reg[5:0]};

	assign stream_zero_swap_mask_out = {stream_zero_swap_high_reg,
		stream_zero_swap_low_reg}; // RQ17
	assign stream_one_swap_mask_out = {stream_one_swap_high_reg,
		stream_one_swap_low_reg}; // RQ17
	assign led_button_state_out = led_button_state_reg; // RQ18
	assign lower_port_first_out = led_stream_order_reg; // RQ19

endmodule : board_reset_led_ctrl_regs

// File: verilog/reg_port_if.sv
`timescale 1ns/1ps
interface reg_port_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;

	modport master (output addr, output wdata, output wr, output rd, input rdata);
	modport slave  (input addr, input wdata, input wr, input rd, output rdata);
endinterface : reg_port_if

// File: verilog/test_led_decode.sv
`timescale 1ns/1ps
module test_led_decode
	import board_ctrl_pkg::*;
(
	input  wire logic [7:0] asic_led_in,
	input  wire logic [7:0] test_led_in,
	output logic            stream_zero_test_out,
	output logic            stream_one_test_out,
	output logic            single_led_out,
	output logic [4:0]      test_led_num_out,
	output logic [2:0]      test_rgb_out
);
	led_test_sel_type sel;

	// ----------------------------------------
	// test selection decode
	// ----------------------------------------
	always_comb begin
		sel = led_test_sel_type'(asic_led_in[TEST_SEL_LSB +: 2]);
		stream_zero_test_out = 1'b0;
		stream_one_test_out  = 1'b0;
		single_led_out       = 1'b0;
		unique case (sel) // RQ11
			SINGLE_STREAM_ZERO: begin
				stream_zero_test_out = 1'b1;
				single_led_out       = 1'b1;
			end
			SINGLE_STREAM_ONE: begin
				stream_one_test_out = 1'b1;
				single_led_out      = 1'b1;
			end
			ALL_STREAM_ZERO: begin
				stream_zero_test_out = 1'b1;
			end
			ALL_STREAM_ONE: begin
				stream_one_test_out = 1'b1;
			end
		endcase
	end

	assign test_led_num_out = test_led_in[TEST_NUM_BITS-1:0]; // RQ13
	// rgb order red, green, blue
	assign test_rgb_out = {test_led_in[TEST_RED_BIT], test_led_in[TEST_GREEN_BIT],
		test_led_in[TEST_BLUE_BIT]}; // RQ14

endmodule : test_led_decode
